// ==== pkg/ssd_map.svh ====
/*
 * Encodings, field positions, flag positions and reset values for the
 * subtract / nibble exchange / direction load execution block.
 * Assumes a 12-bit instruction word and an 8-bit data path.
 */
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// ************************************************************
// Instruction fields
// ************************************************************
`define SSD_OPC_HI        11
`define SSD_OPC_LO        6
`define SSD_DEST_BIT      5
`define SSD_FADDR_HI      4
`define SSD_FADDR_LO      0
`define SSD_DIRSEL_HI     2
`define SSD_DIRSEL_LO     0

// ************************************************************
// Opcode patterns
// ************************************************************
`define SSD_OPC_SUB       6'h02
`define SSD_OPC_SWAP      6'h0e
`define SSD_DIRLOAD_MASK  12'hff8
`define SSD_DIRLOAD_VAL   12'h000
`define SSD_DIRSEL_MIN    3'h5
`define SSD_DIRSEL_MAX    3'h7
`define SSD_DEST_ACC      1'h0
`define SSD_DEST_FILE     1'h1

// ************************************************************
// Status flag positions
// ************************************************************
`define SSD_FLAG_CARRY    0
`define SSD_FLAG_DIGIT    1
`define SSD_FLAG_ZERO     2

// ************************************************************
// Reset values
// ************************************************************
`define SSD_ACC_RESET     8'h00
`define SSD_STATUS_RESET  3'h0
`define SSD_DIR_RESET     8'hff

`endif

// ==== pkg/ssd_pkg.sv ====
/*
 * Types shared by the execution block files.
 * Assumes ssd_map.svh supplies all numeric constants.
 */
package ssd_pkg;

    // Instruction classes recognised by this block
    typedef enum {
        SSD_OP_NONE,
        SSD_OP_SUB,
        SSD_OP_SWAP,
        SSD_OP_DIRLOAD
    } ssd_op_t;

endpackage

// ==== src/ssd_decode.sv ====
/*
 * Combinational decoder: classifies a 12-bit instruction word.
 * Assumes the word is stable for the whole instruction cycle.
 */
`timescale 1ns/1ns
`include "ssd_map.svh"

module ssd_decode
    import ssd_pkg::*;
(
    input  wire logic [11:0] instr,     // Instruction word
    output ssd_op_t          opKind,    // Decoded class
    output logic             destFile,  // Destination is file register
    output logic [4:0]       fileAddr,  // File register address
    output logic [2:0]       dirSel     // Direction register select
);

    logic [5:0] opc;

    // ************************************************************
    // Field extraction and classification
    // ************************************************************
    always_comb
    begin
        opc      = instr[`SSD_OPC_HI:`SSD_OPC_LO];
        destFile = instr[`SSD_DEST_BIT];
        fileAddr = instr[`SSD_FADDR_HI:`SSD_FADDR_LO];
        dirSel   = instr[`SSD_DIRSEL_HI:`SSD_DIRSEL_LO];
        opKind   = SSD_OP_NONE;
        if (opc == `SSD_OPC_SUB)
        begin
            opKind = SSD_OP_SUB;
        end
        else if (opc == `SSD_OPC_SWAP)
        begin
            opKind = SSD_OP_SWAP;
        end
        // Only selects 5..7 of the three-bit field are accepted; selects 0..4 do nothing
        else if (((instr & `SSD_DIRLOAD_MASK) == `SSD_DIRLOAD_VAL) &&
                 (dirSel >= `SSD_DIRSEL_MIN))
        begin
            opKind = SSD_OP_DIRLOAD;
        end
    end

endmodule

// ==== src/ssd_exec.sv ====
/*
 * Execution unit for three instructions of a small 8-bit core:
 * subtract accumulator from file register, nibble exchange, and
 * direction load. Results are registered, so each instruction
 * finishes in the cycle it is presented and the next one sees it.
 * Select codes 8 and 9 do not fit the three-bit operand field and
 * are not built.
 *
 * Assumes the core presents one instruction and its file operand per
 * clock, with fileRdData already holding the file register that the
 * instruction addresses. The core must write the file register back
 * when fileWrEn pulses; this block keeps no file register storage.
 * Assumes all inputs come from logic on the same clock, so none of
 * them is synchronised here.
 */
`timescale 1ns/1ns
`include "ssd_map.svh"

module ssd_exec
    import ssd_pkg::*;
#(
    parameter int DATA_W = 8,  // Data path width
    parameter int DIR_N  = 3   // Direction registers (selects 5..7)
)
(
    input  wire logic               clk,            // 50 MHz core clock
    input  wire logic               reset,          // Sync reset, high
    input  wire logic               instrValid,     // Instruction present
    input  wire logic [11:0]        instr,          // Instruction word
    input  wire logic [DATA_W-1:0]  fileRdData,     // Addressed file value
    output logic [DATA_W-1:0]       accOut,         // Accumulator
    output logic                    carryFlag,      // Carry, 1 = no borrow
    output logic                    digitCarryFlag, // Low nibble carry
    output logic                    zeroFlag,       // Result was zero
    output logic                    fileWrEn,       // File write pulse
    output logic [4:0]              fileWrAddr,     // File write address
    output logic [DATA_W-1:0]       fileWrData,     // File write data
    output logic [DIR_N*DATA_W-1:0] dirRegs         // Direction regs, 5 low
);

    // Decoder outputs
    ssd_op_t           opKind;
    logic              destFile;
    logic [4:0]        fileAddr;
    logic [2:0]        dirSel;

    // Architectural state and its next values
    logic [DATA_W-1:0] acc_q, acc_d;
    logic [2:0]        status_q, status_d;
    logic              fwEn_q, fwEn_d;
    logic [4:0]        fwAddr_q, fwAddr_d;
    logic [DATA_W-1:0] fwData_q, fwData_d;
    logic [DATA_W-1:0] dir_q [DIR_N];
    logic [DATA_W-1:0] dir_d [DIR_N];

    // Arithmetic intermediates
    logic [DATA_W:0]   diff;
    logic [4:0]        lowDiff;
    logic [DATA_W-1:0] swapped;
    logic [2:0]        subFlags;
    logic [DATA_W-1:0] result;
    logic              writeBack;

    // ************************************************************
    // Decode
    // ************************************************************
    // Selects 8 and 9 cannot be coded in the three-bit field, so only
    // three direction registers exist behind selects 5 to 7
    ssd_decode u_decode
    (
        .instr    (instr),
        .opKind   (opKind),
        .destFile (destFile),
        .fileAddr (fileAddr),
        .dirSel   (dirSel)
    );

    // ************************************************************
    // Arithmetic
    // ************************************************************
    // Borrow is caught by a ninth bit: f + ~W + 1 carries out on no
    // borrow, so the carry flag falls straight out of the adder
    always_comb
    begin
        diff     = {1'b0, fileRdData} + {1'b0, ~acc_q} +
                   {{DATA_W{1'b0}}, 1'b1};
        // Same trick on the low nibble gives the digit carry
        lowDiff  = {1'b0, fileRdData[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
        swapped  = {fileRdData[3:0], fileRdData[7:4]};
        subFlags = '0;
        subFlags[`SSD_FLAG_CARRY] = diff[DATA_W];
        subFlags[`SSD_FLAG_DIGIT] = lowDiff[4];
        subFlags[`SSD_FLAG_ZERO]  = (diff[DATA_W-1:0] == '0);
    end

    // ************************************************************
    // Datapath and next state
    // ************************************************************
    // Refused and unknown words fall through with every value held except fileWrEn, which drops to 0
    always_comb
    begin
        result    = '0;
        writeBack = 1'b0;
        acc_d     = acc_q;
        status_d  = status_q;
        fwEn_d    = 1'b0;
        fwAddr_d  = fwAddr_q;
        fwData_d  = fwData_q;
        if (instrValid)
        begin
            case (opKind)
                SSD_OP_SUB:
                begin
                    // Only the subtract touches the flags
                    result    = diff[DATA_W-1:0];
                    writeBack = 1'b1;
                    status_d  = subFlags;
                end
                SSD_OP_SWAP:
                begin
                    // Flags are left as they were
                    result    = swapped;
                    writeBack = 1'b1;
                end
                default:
                begin
                    writeBack = 1'b0;
                end
            endcase
            // Destination bit steers the one result to W or the file
            if (writeBack)
            begin
                if (destFile == `SSD_DEST_ACC)
                begin
                    acc_d = result;
                end
                else
                begin
                    fwEn_d   = 1'b1;
                    fwAddr_d = fileAddr;
                    fwData_d = result;
                end
            end
        end
    end

    // ************************************************************
    // Direction registers
    // ************************************************************
    // One register per direction select, loaded from the accumulator.
    // They reset to all ones and hold until the core loads them.
    genvar gi;
    generate
        for (gi = 0; gi < DIR_N; gi++)
        begin : g_dir
            always_comb
            begin
                dir_d[gi] = dir_q[gi];
                // Load only on an accepted direction load to this select
                if (instrValid && (opKind == SSD_OP_DIRLOAD) &&
                    (dirSel == 3'(gi + 5)))
                begin
                    dir_d[gi] = acc_q;
                end
            end
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    dir_q[gi] <= `SSD_DIR_RESET;
                end
                else
                begin
                    dir_q[gi] <= dir_d[gi];
                end
            end
            assign dirRegs[gi*DATA_W +: DATA_W] = dir_q[gi];
        end
    endgenerate

    // ************************************************************
    // State registers: every result lands at the next edge
    // Write address and data hold between pulses; only fileWrEn marks them
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            acc_q    <= `SSD_ACC_RESET;
            status_q <= `SSD_STATUS_RESET;
            fwEn_q   <= 1'b0;
            fwAddr_q <= 5'h00;
            fwData_q <= '0;
        end
        else
        begin
            acc_q    <= acc_d;
            status_q <= status_d;
            fwEn_q   <= fwEn_d;
            fwAddr_q <= fwAddr_d;
            fwData_q <= fwData_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Every output is a flop output; nothing combinational reaches a pin
    assign accOut         = acc_q;
    assign carryFlag      = status_q[`SSD_FLAG_CARRY];
    assign digitCarryFlag = status_q[`SSD_FLAG_DIGIT];
    assign zeroFlag       = status_q[`SSD_FLAG_ZERO];
    assign fileWrEn       = fwEn_q;
    assign fileWrAddr     = fwAddr_q;
    assign fileWrData     = fwData_q;

endmodule

// ==== testbench/ssd_exec_sva.sv ====
/* Checker for the execution block, watching its top ports only.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`include "ssd_map.svh"
module ssd_exec_sva
    import ssd_pkg::*;
#(
    parameter int DATA_W = 8,  // Data width
    parameter int DIR_N  = 3   // Direction regs
)
(
    input wire logic                    clk,            // Clock
    input wire logic                    reset,          // Reset
    input wire logic                    instrValid,     // Valid
    input wire logic [11:0]             instr,          // Word
    input wire logic [DATA_W-1:0]       fileRdData,     // File value
    input wire logic [DATA_W-1:0]       accOut,         // Accumulator
    input wire logic                    carryFlag,      // Carry
    input wire logic                    digitCarryFlag, // Digit carry
    input wire logic                    zeroFlag,       // Zero
    input wire logic                    fileWrEn,       // Write pulse
    input wire logic [4:0]              fileWrAddr,     // Write address
    input wire logic [DATA_W-1:0]       fileWrData,     // Write data
    input wire logic [DIR_N*DATA_W-1:0] dirRegs         // Direction regs
);
    // ************************************************************
    // Decoded causes and checks
    // ************************************************************
    logic       sub, swp, dir;
    logic [2:0] flg;
    // Decoded here so a wrong decoder in the design cannot hide itself
    assign sub = instrValid && instr[11:6] == `SSD_OPC_SUB;
    assign swp = instrValid && instr[11:6] == `SSD_OPC_SWAP;
    assign dir = instrValid && instr[11:3] == 9'h000;
    assign flg = {carryFlag, digitCarryFlag, zeroFlag};
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_SUB_ACC: assert property (sub && !instr[5] |=>
        accOut == $past(fileRdData - accOut)) else $error("bad acc");
    AST_SUB_FILE: assert property (sub && instr[5] |=> fileWrEn &&
        fileWrData == $past(fileRdData - accOut) &&
        fileWrAddr == $past(instr[4:0])) else $error("bad write");
    AST_SUB_FLAGS: assert property (sub |=>
        carryFlag == $past(fileRdData >= accOut) &&
        zeroFlag == $past(fileRdData == accOut) &&
        digitCarryFlag == $past(fileRdData[3:0] >= accOut[3:0]))
        else $error("bad flags");
    AST_SWAP: assert property (swp && instr[5] |=> $stable(flg) &&
        fileWrData == {$past(fileRdData[3:0]), $past(fileRdData[7:4])})
        else $error("bad swap");
    AST_DIR: assert property (dir && instr[2:0] >= 3'h5 |=>
        dirRegs[8*($past(instr[1:0])-2'h1) +: 8] == $past(accOut) &&
        $stable(flg)) else $error("bad direction load");
    AST_DIR_REFUSE: assert property (dir && instr[2:0] < 3'h5 |=>
        $stable(dirRegs) && !fileWrEn) else $error("bad refusal");
    AST_IDLE: assert property (!instrValid |=>
        !fileWrEn && $stable(accOut)) else $error("change when idle");
    AST_PULSE: assert property (fileWrEn |->
        $past(instrValid) && $past(instr[5])) else $error("bad pulse");
    CVR_SUB: cover property (sub && instr[5]);
    CVR_SWAP: cover property (swp);
    CVR_DIR: cover property (dir && instr[2:0] == 3'h7);
endmodule

bind ssd_exec ssd_exec_sva #(.DATA_W(DATA_W), .DIR_N(DIR_N)) chk (.*);

// ==== testbench/testbench.sv ====
/* Self-checking bench for the execution block.
   Assumes inputs change on the falling edge, outputs settle after rise. */
`timescale 1ns/1ns
module testbench;
    logic        clk, reset, instrValid, carryFlag, digitCarryFlag;
    logic        zeroFlag, fileWrEn;
    logic [11:0] instr;
    logic [7:0]  fileRdData, accOut, fileWrData;
    logic [4:0]  fileWrAddr;
    logic [23:0] dirRegs;
    logic [2:0]  flg;
    int          mismatches, checkCount;
    assign flg = {carryFlag, digitCarryFlag, zeroFlag};
    ssd_exec uut (.*);
    // ************************************************************
    // Clock, tasks and verdict
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Wide enough for the longest packed comparison below
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Held valid between calls, so consecutive calls run back to back
    task automatic exec(input logic [11:0] i, input logic [7:0] f);
        @(negedge clk);
        instr = i;
        fileRdData = f;
        instrValid = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog sized well past the short sequence below
    initial
    begin
        #40000;
        mismatches++;
        complete_run;
    end
    // ************************************************************
    // Sequence
    // ************************************************************
    initial
    begin
        {reset, instrValid, instr, fileRdData} = {1'b1, 1'b0, 12'h0, 8'h0};
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk({accOut, flg, fileWrEn}, 12'h000);
        chk(dirRegs, 24'hffffff);
        exec(12'h381, 8'h20);           // Swap into acc: 0x02
        chk({accOut, flg, fileWrEn}, 12'h020);
        exec(12'h0a1, 8'h01);           // 1 - 2 into file 1
        chk({fileWrData, flg, fileWrEn, fileWrAddr}, 17'h1fe21);
        chk(accOut, 8'h02);
        exec(12'h0a1, 8'h02);           // 2 - 2 = 0
        chk({fileWrData, flg}, 11'h007);
        exec(12'h081, 8'h13);           // 0x13 - 2 into acc
        chk({accOut, flg, fileWrEn}, 12'h11c);
        exec(12'h081, 8'h20);           // Uses new acc at once
        chk({accOut, flg}, 11'h7c);
        exec(12'h3a1, 8'ha5);
        chk({fileWrData, flg, fileWrEn}, 12'h5a9);
        exec(12'h005, 8'h00);
        exec(12'h381, 8'h3c);           // Acc becomes 0xc3
        exec(12'h006, 8'h00);
        exec(12'h007, 8'h00);
        chk({dirRegs, flg}, 27'h61e187c);
        exec(12'h004, 8'h00);           // Select 4 is refused
        chk({dirRegs, fileWrEn}, 25'h187861e);
        exec(12'h1a1, 8'h77);           // Unhandled opcode changes nothing
        chk({accOut, flg, fileWrEn}, 12'hc38);
        @(negedge clk);
        instrValid = 1'b0;
        instr = 12'h0a1;
        repeat (2) @(posedge clk);
        #1;
        chk({accOut, fileWrEn}, 9'h186);
        @(negedge clk);
        reset = 1'b1;
        @(posedge clk);
        #1;
        chk({accOut, dirRegs, flg}, 35'h007fffff8);
        chk({fileWrEn, fileWrAddr, fileWrData}, 14'h0000);
        @(negedge clk);
        reset = 1'b0;
        exec(12'h0a1, 8'h00);           // 0 - 0 right after release
        chk({fileWrData, flg, fileWrEn, fileWrAddr}, 17'h001e1);
        complete_run;
    end
endmodule
